// [fis_slave.sv]
/*
  Two-wire serial slave in front of a byte memory, EEPROM style.
  Assumes open-drain pins resolved outside; lines sampled on clk.
*/
`timescale 1ns/1ps
module fis_slave #(
  parameter logic [3:0] SLAVE_ADDRESS_UPPER_BITS = fis_pkg::UPPER_DEFAULT,
  parameter logic [1:0] MEM_SIZE                 = fis_pkg::SIZE_8K,
  parameter logic       PROTECT_UPPER_ONLY       = 1'b0,
  parameter int         PAGE_BYTES               = 32
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [2:0] deviceSelectPins,
  input  wire logic       writeProtect,
  output logic            busBusy,
  output logic            flashBusy
);

  // ------------------------------------------------------------------
  // Input synchronisers and glitch filter
  // ------------------------------------------------------------------
  fis_pkg::fis_bus_t meta_q, sync_q, samp_q, filt_q;
  fis_pkg::fis_bus_t filt_d;
  logic [2:0] dsMeta_q, dsSync_q;
  logic       wpMeta_q, wpSync_q;

  // Level takes a new value only after two equal samples (R24)
  always_comb begin
    filt_d = filt_q;
    if (sync_q.scl == samp_q.scl) filt_d.scl = samp_q.scl; // R24
    if (sync_q.sda == samp_q.sda) filt_d.sda = samp_q.sda; // R24
  end

  // Two flops per outside input before any logic reads it
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q     <= '{scl: 1'b1, sda: 1'b1};
      sync_q     <= '{scl: 1'b1, sda: 1'b1};
      samp_q     <= '{scl: 1'b1, sda: 1'b1};
      filt_q     <= '{scl: 1'b1, sda: 1'b1};
      dsMeta_q   <= 3'h0;
      dsSync_q   <= 3'h0;
      wpMeta_q   <= 1'b0;
      wpSync_q   <= 1'b0;
    end else begin
      meta_q     <= '{scl: sclIn, sda: sdaIn};
      sync_q     <= meta_q;
      samp_q     <= sync_q;
      filt_q     <= filt_d;
      dsMeta_q   <= deviceSelectPins;
      dsSync_q   <= dsMeta_q;
      wpMeta_q   <= writeProtect;
      wpSync_q   <= wpMeta_q;
    end
  end

  // ------------------------------------------------------------------
  // Bus condition decode
  // ------------------------------------------------------------------
  logic sclRise, sclFall, startCond, stopCond;
  // Edges taken from the filter's next value: saves a clock, so the
  // answer on the data line settles before the clock rises again (R5)
  assign sclRise   = filt_d.scl & ~filt_q.scl;
  assign sclFall   = ~filt_d.scl & filt_q.scl;
  // Start and stop: data edge while clock held high (R6, R7)
  assign startCond = filt_d.scl & filt_q.scl
                     & filt_q.sda & ~filt_d.sda;         // R6
  assign stopCond  = filt_d.scl & filt_q.scl
                     & ~filt_q.sda & filt_d.sda;         // R7

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // Address match; low select positions become address bits (R15, R17)
  function automatic logic addrMatch(input logic [6:0] a,
                                     input logic [2:0] ds);
    logic [2:0] mask;
    mask = 3'h7;
    if (MEM_SIZE == fis_pkg::SIZE_4K) mask = 3'h6;        // R17
    if (MEM_SIZE == fis_pkg::SIZE_8K) mask = 3'h4;        // R18
    addrMatch = (a[6:3] == SLAVE_ADDRESS_UPPER_BITS)      // R14
                && ((a[2:0] & mask) == (ds & mask));       // R15
  endfunction : addrMatch

  // Wrap an address to the configured array size (R3)
  function automatic logic [fis_pkg::ADDR_W-1:0] sizeWrap(
      input logic [fis_pkg::ADDR_W-1:0] a);
    case (MEM_SIZE)
      fis_pkg::SIZE_1K: sizeWrap = {3'h0, a[6:0]};         // R3
      fis_pkg::SIZE_2K: sizeWrap = {2'h0, a[7:0]};
      fis_pkg::SIZE_4K: sizeWrap = {1'b0, a[8:0]};
      default:          sizeWrap = a;
    endcase
  endfunction : sizeWrap

  // Protected location test; top address bit picks the upper half (R20)
  function automatic logic isProtected(
      input logic [fis_pkg::ADDR_W-1:0] a, input logic wp);
    logic hi;
    case (MEM_SIZE)
      fis_pkg::SIZE_1K: hi = a[6];
      fis_pkg::SIZE_2K: hi = a[7];
      fis_pkg::SIZE_4K: hi = a[8];
      default:          hi = a[9];
    endcase
    isProtected = wp & (~PROTECT_UPPER_ONLY | hi);        // R20
  endfunction : isProtected

  // ------------------------------------------------------------------
  // Protocol engine state
  // ------------------------------------------------------------------
  localparam int PW = $clog2(PAGE_BYTES);
  fis_pkg::fis_state_t st_q, st_d, after_q, after_d;
  logic [7:0]  shift_q, shift_d;
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic        busy_q, busy_d, ackDrv_q, ackDrv_d, sdaLow_q, sdaLow_d;
  logic        rnw_q, rnw_d, nack_q, nack_d;
  logic [fis_pkg::ADDR_W-1:0] addr_q, addr_d, base_q, base_d;
  logic [7:0]  page_q [PAGE_BYTES];
  logic [7:0]  page_d [PAGE_BYTES];
  logic [PW:0] cnt_q, cnt_d, wrIdx_q, wrIdx_d;
  logic        flash_q, flash_d, ignore_q, ignore_d;
  logic [7:0]  rdData;
  fis_pkg::fis_wr_t wr;

  // Write into the array is a stream after stop, one byte per clock
  assign wr.en   = flash_q;
  assign wr.addr = sizeWrap(base_q + fis_pkg::ADDR_W'(wrIdx_q));
  assign wr.data = page_q[wrIdx_q[PW-1:0]];

  fis_mem fis_mem_inst (
    .clk    (clk),
    .wr     (wr),
    .rdAddr (addr_q),
    .rdData (rdData)
  );

  // Next-state logic of the byte engine
  always_comb begin
    st_d = st_q; after_d = after_q; shift_d = shift_q;
    bitCnt_d = bitCnt_q; busy_d = busy_q; ackDrv_d = ackDrv_q;
    sdaLow_d = sdaLow_q; rnw_d = rnw_q; nack_d = nack_q;
    addr_d = addr_q; base_d = base_q; page_d = page_q;
    cnt_d = cnt_q; wrIdx_d = wrIdx_q; flash_d = flash_q;
    ignore_d = ignore_q;
    // Internal write sequencing, runs until page is out (R22)
    if (flash_q) begin
      if (wrIdx_q + 1'b1 >= cnt_q) begin
        flash_d = 1'b0;
        cnt_d = '0;
      end
      wrIdx_d = wrIdx_q + 1'b1;
    end
    if (stopCond) begin
      busy_d = 1'b0;                                      // R7
      st_d = fis_pkg::ST_IDLE;
      sdaLow_d = 1'b0;
      if (!flash_q && !ignore_q && cnt_q != '0 && !nack_q) begin
        flash_d = 1'b1;                                   // R22
        wrIdx_d = '0;
      end
      if (!flash_d) cnt_d = '0;
    end else if (startCond) begin
      busy_d = 1'b1;                                      // R6
      st_d = fis_pkg::ST_DEVAD;                           // R9
      bitCnt_d = '0;
      sdaLow_d = 1'b0;
      ignore_d = 1'b0;
    end else if (busy_q) begin
      case (st_q)
        fis_pkg::ST_DEVAD, fis_pkg::ST_BYTAD, fis_pkg::ST_WDATA: begin
          if (sclRise) begin
            shift_d = {shift_q[6:0], filt_q.sda};         // R2
            bitCnt_d = bitCnt_q + 1'b1;
          end
          if (sclFall && bitCnt_q == fis_pkg::BITS_PER_BYTE) begin
            bitCnt_d = '0;
            after_d = st_q;
            st_d = fis_pkg::ST_ACK;                        // R10
            ackDrv_d = 1'b0;
            if (st_q == fis_pkg::ST_DEVAD) begin
              // Ack on ninth clock only if matched and idle (R13, R19)
              if (addrMatch(shift_q[7:1], dsSync_q) && !flash_q) begin // R19
                ackDrv_d = 1'b1;                           // R21
                rnw_d = shift_q[0];                        // R16
                nack_d = 1'b0;
                if (MEM_SIZE == fis_pkg::SIZE_4K)
                  addr_d[8] = shift_q[1];                  // R17
                if (MEM_SIZE == fis_pkg::SIZE_8K)
                  addr_d[9:8] = {shift_q[2], shift_q[1]};  // R18
                if (!shift_q[0]) cnt_d = '0;
              end else begin
                ignore_d = 1'b1;                           // R13
              end
            end else if (st_q == fis_pkg::ST_BYTAD) begin
              addr_d[7:0] = shift_q;
              addr_d = sizeWrap(addr_d);
              base_d = addr_d;
              ackDrv_d = 1'b1;                             // R23
            end else begin
              // First data byte to a protected spot refused (R23)
              if (isProtected(addr_q, wpSync_q) || nack_q) begin
                nack_d = 1'b1;                             // R12
              end else if (cnt_q < PAGE_BYTES[PW:0]) begin
                page_d[cnt_q[PW-1:0]] = shift_q;
                cnt_d = cnt_q + 1'b1;
                addr_d = sizeWrap(addr_q + 1'b1);
                ackDrv_d = 1'b1;                           // R11
              end else begin
                nack_d = 1'b1;                             // R12
              end
            end
            sdaLow_d = ackDrv_d; // R21
          end
        end
        fis_pkg::ST_ACK: begin
          // Hold during whole high time, release at fall (R11)
          sdaLow_d = ackDrv_q & ~(sclFall && bitCnt_q != '0);
          if (sclFall && bitCnt_q == '0 && sdaLow_q) begin
            bitCnt_d = 4'h1;
          end else if (sclRise) begin
            bitCnt_d = 4'h1;
          end else if (sclFall && bitCnt_q != '0) begin
            bitCnt_d = '0;
            ackDrv_d = 1'b0;
            if (!ackDrv_q) begin
              st_d = fis_pkg::ST_IDLE;                     // R12
            end else if (after_q == fis_pkg::ST_DEVAD && rnw_q) begin
              st_d = fis_pkg::ST_RDATA;
              shift_d = rdData;
              sdaLow_d = ~rdData[7];                       // R5
              addr_d = sizeWrap(addr_q + 1'b1);
            end else if (after_q == fis_pkg::ST_DEVAD) begin
              st_d = fis_pkg::ST_BYTAD;
            end else begin
              st_d = fis_pkg::ST_WDATA;
            end
          end
        end
        fis_pkg::ST_RDATA: begin
          // Drive bits MSB first, change only while clock low (R5)
          sdaLow_d = ~shift_q[7];
          if (sclFall) begin
            shift_d = {shift_q[6:0], 1'b1};
            bitCnt_d = bitCnt_q + 1'b1;
            if (bitCnt_q == fis_pkg::BITS_PER_BYTE - 1'b1) begin
              st_d = fis_pkg::ST_RACK;                     // R10
              sdaLow_d = 1'b0;
              bitCnt_d = '0;
            end else begin
              sdaLow_d = ~shift_q[6];                      // R5
            end
          end
        end
        fis_pkg::ST_RACK: begin
          // Master ack continues the read, no-ack ends it
          sdaLow_d = 1'b0;
          if (sclRise) begin
            rnw_d = ~filt_q.sda;
          end
          if (sclFall) begin
            if (rnw_q) begin
              st_d = fis_pkg::ST_RDATA;
              shift_d = rdData;
              sdaLow_d = ~rdData[7];
              addr_d = sizeWrap(addr_q + 1'b1);
            end else begin
              st_d = fis_pkg::ST_IDLE;
            end
          end
        end
        default: st_d = fis_pkg::ST_IDLE;
      endcase
    end
  end

  // Registered state of the engine
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= fis_pkg::ST_IDLE; after_q <= fis_pkg::ST_IDLE;
      shift_q <= fis_pkg::BYTE_IDLE; bitCnt_q <= '0; busy_q <= 1'b0;
      ackDrv_q <= 1'b0; sdaLow_q <= 1'b0; rnw_q <= 1'b0; nack_q <= 1'b0;
      addr_q <= fis_pkg::ADDR_ZERO; base_q <= fis_pkg::ADDR_ZERO;
      cnt_q <= '0; wrIdx_q <= '0; flash_q <= 1'b0; ignore_q <= 1'b0;
    end else begin
      st_q <= st_d; after_q <= after_d; shift_q <= shift_d;
      bitCnt_q <= bitCnt_d; busy_q <= busy_d; ackDrv_q <= ackDrv_d;
      sdaLow_q <= sdaLow_d; rnw_q <= rnw_d; nack_q <= nack_d;
      addr_q <= addr_d; base_q <= base_d; cnt_q <= cnt_d;
      wrIdx_q <= wrIdx_d; flash_q <= flash_d; ignore_q <= ignore_d;
    end
  end

  // Page buffer has no reset; contents only matter after loading
  always_ff @(posedge clk) begin
    page_q <= page_d;
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Open drain: output value always low, enable pulls (R1)
  always_ff @(posedge clk) begin
    if (reset) begin
      sdaOe  <= 1'b0;
      sdaOut <= 1'b0;
      sclOe  <= 1'b0;
      sclOut <= 1'b0;
    end else begin
      sdaOe  <= sdaLow_d;                                  // R1
      sdaOut <= 1'b0;
      sclOe  <= 1'b0;                                      // R25
      sclOut <= 1'b0;
    end
  end

  assign busBusy   = busy_q;
  assign flashBusy = flash_q;

endmodule : fis_slave

// [fis_pkg.sv]
/*
  Constants, types and the behaviour list for the two-wire flash slave.
  Assumes a 50 MHz system clock; no other files needed before this one.
*/
// Functional notes
// R1 - Data and clock lines are driven only open-drain: pull low or release.
// R2 - Bytes move serially eight bits at a time, bus up to 100 Kbit/s.
// R3 - Memory size selectable: 128, 256, 512 or 1024 bytes.
// R4 - Master starts a transfer only while both lines are released high.
// R5 - Data line changes only while clock is low; stable while high.
// R6 - Data falling while clock high is start; bus busy from then.
// R7 - Data rising while clock high is stop; bus free afterwards.
// R8 - Only the master makes start and stop; bus busy until stop.
// R9 - Repeated start is handled exactly like a start.
// R10 - Ninth clock per byte is acknowledge; transmitter releases data line.
// R11 - Receiver acknowledges by holding data low through the clock-high time.
// R12 - Slave leaves data high on the ninth clock when it cannot take a byte.
// R13 - No acknowledge of a new transfer while flash erase or write runs.
// R14 - Upper four address bits are a parameter, default 1010.
// R15 - Next three address bits match the three device select inputs.
// R16 - Eighth address bit: 1 means read, 0 means write.
// R17 - 4-Kbit size: lowest select position becomes byte address bit eight.
// R18 - 8-Kbit size: two lowest positions become byte address bits eight, nine.
// R19 - Acknowledge only a matching address, then read or write by direction.
// R20 - Write protect input blocks writes: whole array or upper half option.
// R21 - Address acknowledge is driven on the ninth clock after start.
// R22 - Flash write of received bytes starts only after the stop.
// R23 - Protected write: ack address bytes, not-acknowledge first data byte.
// R24 - Lines sampled on system clock, synchronised, single glitches filtered.
// R25 - Clock line never stretched; busy shown only by withholding ack.
package fis_pkg;

  // ------------------------------------------------------------------
  // Sizes and codes
  // ------------------------------------------------------------------
  localparam int          ADDR_W       = 10;
  localparam int          MEM_DEPTH    = 1024;
  localparam int          BIT_CNT_W    = 4;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  UPPER_DEFAULT = 4'hA;
  localparam logic [1:0]  SIZE_1K = 2'h0;
  localparam logic [1:0]  SIZE_2K = 2'h1;
  localparam logic [1:0]  SIZE_4K = 2'h2;
  localparam logic [1:0]  SIZE_8K = 2'h3;
  localparam logic [7:0]  BYTE_IDLE = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;

  // Least bus bit time and the matching count of system clocks
  localparam int CLK_MHZ     = 50;
  localparam int BIT_TIME_NS = 10000;
  localparam int BIT_CYCLES  = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEVAD = 3'b001,
    ST_BYTAD = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK   = 3'b101,
    ST_RACK  = 3'b110
  } fis_state_t;

  // Write port into the memory
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fis_wr_t;

  // Sampled bus levels
  typedef struct packed {
    logic scl;
    logic sda;
  } fis_bus_t;

endpackage : fis_pkg

// [fis_mem.sv]
/*
  Byte memory standing in for the flash array behind the slave.
  Assumes a single clock; read data are registered.
*/
`timescale 1ns/1ps
module fis_mem (
  input  wire logic                          clk,
  input  wire fis_pkg::fis_wr_t              wr,
  input  wire logic [fis_pkg::ADDR_W-1:0]    rdAddr,
  output logic      [7:0]                    rdData
);
  logic [7:0] mem [fis_pkg::MEM_DEPTH];

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // Write then registered read, one cycle latency
  always_ff @(posedge clk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
    rdData <= mem[rdAddr];
  end
endmodule : fis_mem

// [fis_master_model.sv]
/*
  Behavioural two-wire bus master on the slave's far side.
  Assumes pull-ups on both wires; the bench sequences frames by task.
*/
`timescale 1ns/1ps
module fis_master_model (
  output logic      sclLow,
  output logic      sdaLow,
  input  wire logic scl,
  input  wire logic sda
);
  // ------------------------------------------------------------
  // Bus primitives, quarter of the 160 ns link period
  // ------------------------------------------------------------
  localparam time QB = 40;

  // Both lines released at time zero
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  // Start or repeated start; caller starts on a free bus, or mid-frame for the repeated start in read_at
  task automatic start_cond();
    sdaLow = 1'b0;
    #(3*QB);
    sclLow = 1'b0;
    #(2*QB);
    sdaLow = 1'b1;
    #(2*QB);
    sclLow = 1'b1;
    #QB;
  endtask : start_cond

  // Stop; long low first so a slave ack release lands before SCL rises
  task automatic stop_cond();
    sdaLow = 1'b1;
    #(3*QB);
    sclLow = 1'b0;
    #(2*QB);
    sdaLow = 1'b0;
    #QB;
  endtask : stop_cond

  // One bit: 100 ns low, 60 ns high; the long low lets the slave's
  // registered answer settle before the clock rises
  task automatic put_bit(input logic b, output logic r);
    sdaLow = !b;
    #(QB + 20);
    sclLow = 1'b0;
    #(QB + 16);
    r = sda;
    #4;
    sclLow = 1'b1;
    #QB;
  endtask : put_bit

  // Byte out MSB first, line released for the ack clock
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ack = !r;
    #(2*QB);
  endtask : tx_byte

  // Byte in; master pulls low through the ack clock to continue
  task automatic rx_byte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(!ackIt, r);
    #(2*QB);
  endtask : rx_byte

  // One-sample SDA pulse on an idle bus, to exercise the filter
  task automatic glitch();
    sdaLow = 1'b1;
    #20;
    sdaLow = 1'b0;
    #(4*QB);
  endtask : glitch
endmodule : fis_master_model

// [fis_slave_properties.sv]
/*
  Concurrent checks on the two-wire slave's pins and status outputs.
  Assumes one clock domain with synchronous reset; bound below.
*/
`timescale 1ns/1ps
module fis_slave_properties (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [2:0] deviceSelectPins,
  input wire logic       writeProtect,
  input wire logic       busBusy,
  input wire logic       flashBusy
);
  // ------------------------------------------------------------
  // Helper: cycles since the raw lines last showed a stop
  // ------------------------------------------------------------
  logic       sclPrev_q;
  logic       sdaPrev_q;
  logic [3:0] stopAge_q;
  logic [3:0] stopAge_d;

  // Age saturates so a long idle never wraps back to a small count
  always_comb begin
    stopAge_d = (stopAge_q == 4'hF) ? stopAge_q : stopAge_q + 4'h1;
    if (sclIn && sclPrev_q && sdaIn && !sdaPrev_q) begin
      stopAge_d = 4'h0;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    sclPrev_q <= reset ? 1'b1 : sclIn;
    sdaPrev_q <= reset ? 1'b1 : sdaIn;
    stopAge_q <= reset ? 4'hF : stopAge_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_scl_released;
    sclOe == 1'b0;
  endproperty
  a_scl_released: assert property (p_scl_released)
    else $error("slave drove the clock line");

  property p_sda_open_drain;
    sdaOe |-> sdaOut == 1'b0;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain)
    else $error("data line driven high");

  // Two equal samples needed, so a one-sample pulse is not a start
  property p_start_busy;
    (sclIn && $past(sdaIn) && !sdaIn) ##1 (sclIn && !sdaIn)
      |-> ##[1:8] busBusy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start not followed by busy");

  property p_stop_free;
    (sclIn && !$past(sdaIn) && sdaIn) ##1 (sclIn && sdaIn)
      |-> ##[1:8] !busBusy;
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("stop not followed by free bus");

  property p_busy_until_stop;
    $fell(busBusy) |-> stopAge_q <= 4'h8;
  endproperty
  a_busy_until_stop: assert property (p_busy_until_stop)
    else $error("bus freed without a stop");

  property p_no_ack_flash;
    flashBusy |-> !sdaOe;
  endproperty
  a_no_ack_flash: assert property (p_no_ack_flash)
    else $error("data line pulled during memory write");

  property p_write_after_stop;
    $rose(flashBusy) |-> !busBusy && stopAge_q <= 4'hA;
  endproperty
  a_write_after_stop: assert property (p_write_after_stop)
    else $error("memory write began without a stop");

  property p_ack_hold;
    $rose(sdaOe) |-> sdaOe [*6];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data line low shorter than a clock high");

  c_start: cover property ($rose(busBusy));
  c_flash: cover property ($rose(flashBusy));
  c_ack: cover property ($rose(sdaOe));
endmodule : fis_slave_properties

bind fis_slave fis_slave_properties fis_slave_properties_inst (
  .clk(clk), .reset(reset), .sclIn(sclIn), .sclOut(sclOut),
  .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .deviceSelectPins(deviceSelectPins), .writeProtect(writeProtect),
  .busBusy(busBusy), .flashBusy(flashBusy));

// [fis_slave_tb.sv]
/*
  Self-checking bench for the two-wire flash slave in 8-Kbit form.
  Assumes the master model and checker files are compiled first.
*/
`timescale 1ns/1ps
module fis_slave_tb;
  // ------------------------------------------------------------
  // Signals and wiring
  // ------------------------------------------------------------
  logic       clk;
  logic       reset;
  logic       sclOut;
  logic       sclOe;
  logic       sdaOut;
  logic       sdaOe;
  logic       busBusy;
  logic       flashBusy;
  logic [2:0] deviceSelectPins;
  logic       writeProtect;
  logic       mSclLow;
  logic       mSdaLow;
  wire  logic sclWire;
  wire  logic sdaWire;
  logic [7:0] rd;
  int         err_total;
  int         n_compared;

  // Wired-AND with pull-ups: any enabled driver pulls the line low
  assign sclWire = !(mSclLow || (sclOe && !sclOut));
  assign sdaWire = !(mSdaLow || (sdaOe && !sdaOut));

  fis_slave fis_slave_inst (.clk(clk), .reset(reset), .sclIn(sclWire),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .deviceSelectPins(deviceSelectPins),
    .writeProtect(writeProtect), .busBusy(busBusy), .flashBusy(flashBusy));
  fis_master_model m (.sclLow(mSclLow), .sdaLow(mSdaLow), .scl(sclWire),
    .sda(sdaWire));

  // ------------------------------------------------------------
  // Compare and closing tasks
  // ------------------------------------------------------------
  task automatic check_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask : check_bit

  task automatic check_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check_byte

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Transfers: hi is byte address bits nine and eight
  // ------------------------------------------------------------
  task automatic write_at(input logic [1:0] hi, input logic [7:0] a,
                          input logic [7:0] d, input logic ok);
    logic k;
    logic seen;
    seen = 1'b0;
    m.start_cond();
    m.tx_byte({4'hA, 1'b1, hi, 1'b0}, k);
    check_bit("select ack", 1'b1, k);
    check_bit("busy in frame", 1'b1, busBusy);
    m.tx_byte(a, k);
    check_bit("address ack", 1'b1, k);
    m.tx_byte(d, k);
    check_bit("data ack", ok, k);
    check_bit("no early write", 1'b0, flashBusy);
    m.stop_cond();
    // Write runs a clock per byte, so 40 cycles bound it
    repeat (40) begin
      @(negedge clk);
      seen = seen | (flashBusy === 1'b1);
    end
    check_bit("memory write", ok, seen);
    check_bit("free after stop", 1'b0, busBusy);
  endtask : write_at

  // Random read: address set by a write frame, then repeated start
  task automatic read_at(input logic [1:0] hi, input logic [7:0] a,
                         output logic [7:0] d);
    logic k;
    m.start_cond();
    m.tx_byte({4'hA, 1'b1, hi, 1'b0}, k);
    m.tx_byte(a, k);
    m.start_cond();
    m.tx_byte({4'hA, 1'b1, hi, 1'b1}, k);
    check_bit("read select ack", 1'b1, k);
    m.rx_byte(1'b0, d);
    m.stop_cond();
  endtask : read_at

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Same low byte, two upper address pairs: both must stay apart
  task automatic t_write_read();
    write_at(2'b10, 8'hA7, 8'h5C, 1'b1);
    write_at(2'b01, 8'hA7, 8'hC3, 1'b1);
    read_at(2'b10, 8'hA7, rd);
    check_byte("read upper pair", 8'h5C, rd);
    read_at(2'b01, 8'hA7, rd);
    check_byte("read lower pair", 8'hC3, rd);
  endtask : t_write_read

  // Wrong upper bits, wrong select bit, either direction
  task automatic t_mismatch();
    logic [7:0] bad [3] = '{8'hBC, 8'hA4, 8'hA3};
    logic       k;
    foreach (bad[i]) begin
      m.start_cond();
      m.tx_byte(bad[i], k);
      check_bit("foreign address", 1'b0, k);
      m.stop_cond();
    end
  endtask : t_mismatch

  // Protected write is refused and leaves the stored byte alone
  task automatic t_protect();
    writeProtect = 1'b1;
    repeat (4) @(negedge clk);
    write_at(2'b10, 8'hA7, 8'h33, 1'b0);
    writeProtect = 1'b0;
    repeat (4) @(negedge clk);
    read_at(2'b10, 8'hA7, rd);
    check_byte("protected byte", 8'h5C, rd);
  endtask : t_protect

  // A pulse one sample long must not open a frame
  task automatic t_glitch();
    m.glitch();
    repeat (8) @(negedge clk);
    check_bit("glitch ignored", 1'b0, busBusy);
  endtask : t_glitch

  // ------------------------------------------------------------
  // Clock, main sequence, watchdog
  // ------------------------------------------------------------
  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Inputs set at time zero, changed on falling edges only
  initial begin
    reset = 1'b1;
    deviceSelectPins = 3'b100;
    writeProtect = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (10) @(negedge clk);
    t_glitch();
    t_write_read();
    t_mismatch();
    t_protect();
    tally_and_finish();
  end

  // Whole run is about 46 us; some thirteen times that means a hang
  initial begin
    #600000;
    err_total++;
    tally_and_finish();
  end
endmodule : fis_slave_tb
